/* prctl_defines.svh */
`ifndef PRCTL_DEFINES_SVH
`define PRCTL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register word indices on the Wishbone slave, compared with address bits 3:2
// ----------------------------------------------------------------------
`define PRCTL_ADR_CONFIG     2'h0
`define PRCTL_ADR_STATUS     2'h1
`define PRCTL_ADR_PATTERN    2'h2
`define PRCTL_ADR_OPEN       2'h3

// ----------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------
`define PRCTL_RL_RESET       5'h0b
`define PRCTL_RL_MIN         5'h02
`define PRCTL_ST_CONFLICT    8

// ----------------------------------------------------------------------
// Mode register selection and address fields of mode-set, read and precharge commands
// ----------------------------------------------------------------------
`define PRCTL_MR_BURST       3'h0
`define PRCTL_MR_PATTERN     3'h3
`define PRCTL_MR_PREAMBLE    3'h4
`define PRCTL_A_PAT_EN       2
`define PRCTL_A_WR_PRE       12
`define PRCTL_A_RD_PRE       11
`define PRCTL_A_TRAIN        10
`define PRCTL_A_CHOP         12
`define PRCTL_A_ALL_BANKS    10
`define PRCTL_PAGE0          2'h0
`define PRCTL_BURST_OTF      2'h1
`define PRCTL_BURST_CHOP     2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PRCTL_CLK_NS         20
`define PRCTL_SDO_EXTRA_NS   9
`define PRCTL_SDO_EXTRA_CYC  ((`PRCTL_SDO_EXTRA_NS / `PRCTL_CLK_NS) > 0 ? (`PRCTL_SDO_EXTRA_NS / `PRCTL_CLK_NS) : 1)

`endif

/* prctl_pkg.sv */
package prctl_pkg;

   // ----------------------------------------------------------------------
   // Command kinds decoded by the controller side.
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_MODE_SET,
      CMD_ACTIVATE,
      CMD_READ,
      CMD_WRITE,
      CMD_PRECHARGE,
      CMD_REFRESH
   } prctl_kind_t;

   // One command as sampled on a clock edge.
   typedef struct packed {
      prctl_kind_t kind;
      logic [1:0]  bg;
      logic [1:0]  ba;
      logic [16:0] addr;
   } prctl_cmd_t;

   // Data and strobe pins, each with its own output enable.
   typedef struct packed {
      logic [7:0] dq;
      logic       dq_oe;
      logic       strobe_t;
      logic       strobe_c;
      logic       strobe_oe;
   } prctl_pins_t;

   // Read burst engine states.
   typedef enum logic [1:0] {
      RD_IDLE,
      RD_WAIT,
      RD_DATA,
      RD_POST
   } prctl_rd_state_t;

endpackage

/* prctl_bank_row.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Open-row tracker of one bank
// ----------------------------------------------------------------------
module prctl_bank_row #(
   parameter int ROW_W = 15
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Commands aimed at this bank
   input  wire logic             act,
   input  wire logic             pre,
   input  wire logic [ROW_W-1:0] row,
   // State
   output logic                  is_open,
   output logic [ROW_W-1:0]      open_row,
   output logic                  conflict
);
   import prctl_pkg::*;

   // An activate to a bank that is still open would lose the open row, so it is refused and flagged.
   assign conflict = act & is_open;

   // Precharge closes the row; an activate opens one only on a closed bank.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         is_open  <= 1'b0;
         open_row <= '0;
      end else if (pre) begin
         is_open <= 1'b0;
      end else if (act && !is_open) begin
         is_open  <= 1'b1;
         open_row <= row;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_ROW_OPEN: assert property (act && !is_open && !pre |=> is_open && open_row == $past(row))
      else $error("Activate did not open the row.");
   AST_ROW_KEEP: assert property (is_open && !pre |=> is_open && $stable(open_row))
      else $error("Open row changed without a precharge.");

endmodule

`default_nettype wire

/* prctl_core.sv */
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "prctl_defines.svh"

module prctl_core #(
   parameter int MODE_UPDATE_CYC = 24,
   parameter int ROW_W           = 15
) (
   // Clock and reset
   input  wire logic                  CLOCK,
   input  wire logic                  RST_N,
   // Wishbone slave
   input  wire logic                  WB_CYC_I,
   input  wire logic                  WB_STB_I,
   input  wire logic                  WB_WE_I,
   input  wire logic [3:0]            WB_ADR_I,
   input  wire logic [3:0]            WB_SEL_I,
   input  wire logic [31:0]           WB_DAT_I,
   output logic      [31:0]           WB_DAT_O,
   output logic                       WB_ACK_O,
   // Command side from the memory controller
   input  wire prctl_pkg::prctl_cmd_t CMD,
   // Data and strobe pins
   output prctl_pkg::prctl_pins_t     PINS
);
   import prctl_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic            pat_en_r;    // Pattern access mode enabled.
   logic [1:0]      page_r;      // Selected pattern page.
   logic [1:0]      burst_r;     // Burst field of the burst config register.
   logic            wr_pre2_r;   // Two-clock write preamble.
   logic            rd_pre2_r;   // Two-clock read preamble.
   logic            train_r;     // Read preamble training active.
   logic [7:0]      loc_r [4];   // Page-0 pattern locations.
   logic [4:0]      rl_r;        // Read latency in clocks, set by software.
   logic            conflict_r;  // Sticky: activate hit an open bank.
   logic            ack_r;       // Bus answer.
   logic [31:0]     dat_r;       // Bus read data.
   prctl_rd_state_t rd_state;    // Read burst engine state.
   logic [4:0]      cnt_r;       // Latency countdown.
   logic [2:0]      ui_r;        // Unit interval within the burst.
   logic            chop_r;      // Current burst is chopped.
   logic [1:0]      sel_r;       // Location read by the current burst.
   prctl_pins_t     pins_r;      // Registered pin drive.
   prctl_pins_t     pins_nxt;    // Next pin drive.

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   wire [2:0] mr_sel    = {CMD.bg[0], CMD.ba};
   wire       is_mrs    = CMD.kind == CMD_MODE_SET;
   wire       mrs_burst = is_mrs && mr_sel == `PRCTL_MR_BURST;
   wire       mrs_pat   = is_mrs && mr_sel == `PRCTL_MR_PATTERN;
   wire       mrs_pre   = is_mrs && mr_sel == `PRCTL_MR_PREAMBLE;
   wire       is_act    = CMD.kind == CMD_ACTIVATE;
   wire       is_pre    = CMD.kind == CMD_PRECHARGE;
   wire [3:0] bank_idx  = {CMD.bg, CMD.ba};
   // Writes to pages other than zero are dropped silently.
   wire       pat_wr    = CMD.kind == CMD_WRITE && pat_en_r && page_r == `PRCTL_PAGE0;
   // A read is taken only while the burst engine is idle; overlapping reads are not queued.
   wire       pat_rd    = CMD.kind == CMD_READ && pat_en_r && page_r == `PRCTL_PAGE0 && rd_state == RD_IDLE;
   // Address 12 low picks a chopped burst only when the burst field says on the fly.
   wire       rd_chop   = burst_r == `PRCTL_BURST_CHOP ||
                          (burst_r == `PRCTL_BURST_OTF && !CMD.addr[`PRCTL_A_CHOP]);
   wire [4:0] pre_len   = rd_pre2_r ? 5'h02 : 5'h01;
   wire [4:0] rl_load   = rl_r - 5'h01;
   wire [7:0] rd_byte   = loc_r[sel_r];
   wire       ui_bit    = rd_byte[ui_r]; // Bit of the unit interval now on the way out.

   // ----------------------------------------------------------------------
   // Bank row trackers
   // ----------------------------------------------------------------------
   logic [15:0] bank_open;
   logic [15:0] bank_conf;

   for (genvar i = 0; i < 16; i++) begin : g_bank
      wire this_bank = bank_idx == 4'(i);
      prctl_bank_row #(.ROW_W(ROW_W)) u_row (
         .clk      (CLOCK),
         .rst_n    (RST_N),
         .act      (is_act && this_bank),
         .pre      (is_pre && (this_bank || CMD.addr[`PRCTL_A_ALL_BANKS])),
         .row      (CMD.addr[ROW_W-1:0]),
         .is_open  (bank_open[i]),
         .open_row (),
         .conflict (bank_conf[i])
      );
   end

   // ----------------------------------------------------------------------
   // Mode registers
   // ----------------------------------------------------------------------
   // Mode-set commands load the mode fields; training is held off outside pattern mode.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pat_en_r  <= 1'b0;
         page_r    <= 2'h0;
         burst_r   <= 2'h0;
         wr_pre2_r <= 1'b0;
         rd_pre2_r <= 1'b0;
         train_r   <= 1'b0;
      end else begin
         if (mrs_burst) begin
            burst_r <= CMD.addr[1:0];
         end
         if (mrs_pat) begin
            pat_en_r <= CMD.addr[`PRCTL_A_PAT_EN];
            page_r   <= CMD.addr[1:0];
         end
         if (mrs_pre) begin
            wr_pre2_r <= CMD.addr[`PRCTL_A_WR_PRE];
            rd_pre2_r <= CMD.addr[`PRCTL_A_RD_PRE];
            train_r   <= CMD.addr[`PRCTL_A_TRAIN] && pat_en_r;
         end else if (mrs_pat && !CMD.addr[`PRCTL_A_PAT_EN]) begin
            train_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pattern locations
   // ----------------------------------------------------------------------
   // The bank-select bits pick the location and address 7:0 land as UI 7:0.
   // Address 10 and the group bits are not looked at.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         for (int k = 0; k < 4; k++) begin
            loc_r[k] <= 8'h00;
         end
      end else if (pat_wr) begin
         loc_r[CMD.ba] <= CMD.addr[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // Read burst engine
   // ----------------------------------------------------------------------
   // Counts the read latency, then walks eight unit intervals, then one postamble slot.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rd_state <= RD_IDLE;
         cnt_r    <= 5'h00;
         ui_r     <= 3'h0;
         chop_r   <= 1'b0;
         sel_r    <= 2'h0;
      end else begin
         case (rd_state)
            RD_IDLE: begin
               if (pat_rd) begin
                  rd_state <= RD_WAIT;
                  cnt_r    <= rl_load;
                  chop_r   <= rd_chop;
                  sel_r    <= CMD.ba;
               end
            end
            RD_WAIT: begin
               if (cnt_r <= 5'h01) begin
                  rd_state <= RD_DATA;
                  ui_r     <= 3'h0;
               end else begin
                  cnt_r <= cnt_r - 5'h01;
               end
            end
            RD_DATA: begin
               ui_r <= ui_r + 3'h1;
               if (ui_r == 3'h7) begin
                  rd_state <= RD_POST;
               end
            end
            RD_POST: begin
               rd_state <= RD_IDLE;
            end
            default: begin
               rd_state <= RD_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------------
   // Pins are registered so that no decode glitch reaches the data lines.
   always_comb begin
      pins_nxt = '0;
      case (rd_state)
         RD_WAIT: begin
            if (cnt_r <= pre_len) begin
               pins_nxt.strobe_oe = 1'b1;
               pins_nxt.strobe_c  = 1'b1;
            end else if (train_r) begin
               pins_nxt.strobe_oe = 1'b1;
               pins_nxt.strobe_c  = 1'b1;
               pins_nxt.dq        = 8'hff;
               pins_nxt.dq_oe     = 1'b1;
            end
         end
         RD_DATA: begin
            pins_nxt.strobe_oe = 1'b1;
            pins_nxt.strobe_t  = ~ui_r[0];
            pins_nxt.strobe_c  = ui_r[0];
            if (!(chop_r && ui_r[2])) begin
               pins_nxt.dq    = {8{rd_byte[ui_r]}};
               pins_nxt.dq_oe = 1'b1;
            end
         end
         RD_POST: begin
            // One slot of strobe low whatever the preamble length.
            pins_nxt.strobe_oe = 1'b1;
            pins_nxt.strobe_c  = 1'b1;
         end
         default: begin
            if (train_r) begin
               pins_nxt.strobe_oe = 1'b1;
               pins_nxt.strobe_c  = 1'b1;
               pins_nxt.dq        = 8'hff;
               pins_nxt.dq_oe     = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pins_r <= '0;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign PINS = pins_r;

   // ----------------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------------
   wire        wb_req   = WB_CYC_I && WB_STB_I;
   wire        wb_wr    = wb_req && WB_WE_I && ack_r;
   wire [1:0]  wb_reg   = WB_ADR_I[3:2];
   wire        wr_cfg   = wb_wr && wb_reg == `PRCTL_ADR_CONFIG && WB_SEL_I[0];
   wire        clr_conf = wb_wr && wb_reg == `PRCTL_ADR_STATUS && WB_SEL_I[1] &&
                          WB_DAT_I[`PRCTL_ST_CONFLICT];
   wire [31:0] st_word  = {22'h0, rd_state != RD_IDLE, conflict_r, burst_r, train_r,
                           rd_pre2_r, wr_pre2_r, page_r, pat_en_r};
   wire [31:0] rd_word  = wb_reg == `PRCTL_ADR_CONFIG  ? {27'h0, rl_r} :
                          wb_reg == `PRCTL_ADR_STATUS  ? st_word :
                          wb_reg == `PRCTL_ADR_PATTERN ? {loc_r[3], loc_r[2], loc_r[1], loc_r[0]} :
                                                         {16'h0, bank_open};
   wire [4:0]  rl_wr    = WB_DAT_I[4:0] < `PRCTL_RL_MIN ? `PRCTL_RL_MIN : WB_DAT_I[4:0];

   // Answer one cycle after the request; the write lands on the acknowledging edge.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else begin
         ack_r <= wb_req && !ack_r;
         dat_r <= rd_word;
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;

   // Software registers; a new conflict wins over a clear in the same cycle.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rl_r       <= `PRCTL_RL_RESET;
         conflict_r <= 1'b0;
      end else begin
         if (wr_cfg) begin
            rl_r <= rl_wr;
         end
         conflict_r <= (|bank_conf) || (conflict_r && !clr_conf);
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   localparam int SDO_CYC = MODE_UPDATE_CYC + `PRCTL_SDO_EXTRA_CYC;
   logic [7:0] sdo_cnt_r; // Cycles since training was requested without strobes.

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sdo_cnt_r <= 8'h00;
      end else if (train_r && !PINS.strobe_oe) begin
         sdo_cnt_r <= sdo_cnt_r + 8'h01;
      end else begin
         sdo_cnt_r <= 8'h00;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   AST_LOC_WRITE: assert property (pat_wr |=> loc_r[$past(CMD.ba)] == $past(CMD.addr[7:0]))
      else $error("Pattern location did not take the address byte.");
   AST_PAGE_BLOCK: assert property (CMD.kind == CMD_WRITE && page_r != `PRCTL_PAGE0 |=> $stable(loc_r[0]))
      else $error("Write to a nonzero page changed a location.");
   AST_MODE_ENTER: assert property (mrs_pat |=> pat_en_r == $past(CMD.addr[`PRCTL_A_PAT_EN]))
      else $error("Pattern enable did not follow the mode-set.");
   AST_PRE_SELECT: assert property (mrs_pre |=> wr_pre2_r == $past(CMD.addr[`PRCTL_A_WR_PRE])
                                    && rd_pre2_r == $past(CMD.addr[`PRCTL_A_RD_PRE]))
      else $error("Preamble length did not follow the mode-set.");
   AST_TRAIN_ONLY: assert property (train_r |-> pat_en_r)
      else $error("Training active outside pattern mode.");
   AST_TRAIN_PARK: assert property (train_r && rd_state == RD_IDLE |=> PINS.strobe_oe && !PINS.strobe_t
                                    && PINS.strobe_c && PINS.dq == 8'hff)
      else $error("Training idle drive wrong.");
   AST_STROBE_DRIVE: assert property (32'(sdo_cnt_r) <= SDO_CYC)
      else $error("Strobes not driven in time after training entry.");
   AST_POSTAMBLE: assert property (rd_state == RD_DATA && ui_r == 3'h7 |=> rd_state == RD_POST ##1
                                   rd_state == RD_IDLE && PINS.strobe_oe && !PINS.strobe_t)
      else $error("Postamble is not one slot.");
   AST_BURST_ORDER: assert property (rd_state == RD_DATA && !(chop_r && ui_r[2]) |=>
                                     PINS.dq == {8{$past(ui_bit)}} && PINS.dq_oe)
      else $error("Burst data out of order.");
   AST_CHOP_IDLE: assert property (rd_state == RD_DATA && chop_r && ui_r[2] |=> !PINS.dq_oe)
      else $error("Chopped burst drove the last four slots.");
   AST_LATENCY: assert property (pat_rd && rl_r == 5'h04 |=> ##3 rd_state == RD_DATA ##1 PINS.dq_oe)
      else $error("First data not at read latency.");

   COV_PAT_WRITE: cover property (pat_wr ##1 pat_wr);
   COV_PAT_READ: cover property (pat_rd ##[1:40] rd_state == RD_POST);
   COV_TRAIN: cover property (train_r && pat_rd);
   COV_CHOP: cover property (rd_state == RD_DATA && chop_r);

endmodule

`default_nettype wire

/* prctl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Memory controller model: one command per call, then it parks the bus.
// ----------------------------------------------------------------------
module prctl_host_model #(
   parameter int GAP = 6
) (
   // Clock
   input  wire logic            clk,
   // Command bus towards the device
   output prctl_pkg::prctl_cmd_t cmd
);
   import prctl_pkg::*;

   // The bus is idle from time zero.
   initial cmd = '{kind: CMD_NOP, bg: 2'h0, ba: 2'h0, addr: 17'h00000};

   // One idle gap ahead of every command covers all spacing minima; six clocks, never five.
   task automatic send(input prctl_kind_t k, input logic [1:0] g, input logic [1:0] b, input logic [16:0] a);
      repeat (GAP) @(posedge clk);
      cmd <= '{kind: k, bg: g, ba: b, addr: a};
      @(posedge clk);
      // Released lines show the inverse of the last value so a stale copy cannot pass.
      cmd <= '{kind: CMD_NOP, bg: ~g, ba: ~b, addr: ~a};
   endtask
endmodule

`default_nettype wire

/* pattern_register_preamble_ctl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module pattern_register_preamble_ctl_tb;
   import prctl_pkg::*;

   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   localparam int RL = 4;                     // Read latency programmed below.
   logic          clock     = 1'b0;
   logic          rst_n     = 1'b0;
   logic          cyc       = 1'b0;
   logic          stb       = 1'b0;
   logic          we        = 1'b0;
   logic [3:0]    adr       = 4'h0;
   logic [3:0]    sel       = 4'h0;
   logic [3:0]    lanes     = 4'hf;           // Byte lanes used by the next bus call.
   logic [31:0]   dat_w     = 32'h0;
   logic [31:0]   dat_r;
   logic          ack;
   prctl_cmd_t    cmd;
   prctl_pins_t   pins;
   logic [31:0]   pat       = 32'h810f3ca5;   // Bytes of locations 3..0.
   logic [31:0]   q;
   int            bad_count = 0;
   int            n_checks  = 0;
   int            cycles    = 0;

   always #10 clock = ~clock;

   prctl_core #(.MODE_UPDATE_CYC(4), .ROW_W(15)) uut (
      .CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .CMD(cmd), .PINS(pins));

   prctl_host_model #(.GAP(6)) host (.clk(clock), .cmd(cmd));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic print_verdict();
      if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // A hang counts as a mismatch and closes the run.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Classic cycle: request held until ack is sampled high, then released.
   // Only the bench timeout ends a wait for the answer.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, lanes, d};
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      q = dat_r;
      {cyc, stb} <= 2'b00;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // Pattern read; n counts edges after the command edge.
   task automatic burst(input logic [1:0] loc, input bit chop, input int pre);
      logic [7:0] v;
      logic [7:0] m;
      int         k;
      v = pat[loc*8 +: 8];
      host.send(CMD_READ, 2'h0, loc, 17'h01000);
      for (int n = 0; n <= RL + 9; n++) begin
         @(negedge clock);
         k = n - RL;
         m = (chop && k >= 4) ? 8'h00 : 8'hff;
         if (n >= RL - pre && n < RL) begin
            chk({pins.strobe_oe, pins.strobe_t, pins.strobe_c}, 3'b101);
         end else if (k >= 0 && k < 8) begin
            chk({pins.strobe_oe, pins.strobe_t, pins.dq_oe, pins.dq & m},
                {1'b1, k % 2 == 0, m[0], {8{v[k%8]}} & m});
         end else if (k == 8) begin
            chk({pins.strobe_oe, pins.strobe_t, pins.strobe_c}, 3'b101);
         end else if (k == 9) begin
            chk({pins.strobe_oe, pins.dq_oe}, 2'b00);
         end
      end
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rdc(4'h0, 32'h0b);
      rdc(4'h4, 32'h0);
      rdc(4'h8, 32'h0);
      rdc(4'hc, 32'h0);
      wb(1'b1, 4'h0, 32'h1);
      rdc(4'h0, 32'h2);
      // A write without lane 0 must leave the latency alone.
      lanes = 4'he;
      wb(1'b1, 4'h0, 32'h7);
      lanes = 4'hf;
      rdc(4'h0, 32'h2);
      wb(1'b1, 4'h0, RL);
      // No refresh and no data inversion are ever issued by this controller.
      host.send(CMD_PRECHARGE, 2'h0, 2'h0, 17'h00400);
      host.send(CMD_MODE_SET, 2'h0, 2'h3, 17'h00004);
      rdc(4'h4, 32'h1);
      // Ignored bits are set to show they do not reach the stored byte.
      for (int i = 0; i < 4; i++) host.send(CMD_WRITE, 2'h3, i[1:0], {9'h004, pat[i*8 +: 8]});
      rdc(4'h8, pat);
      host.send(CMD_MODE_SET, 2'h0, 2'h3, 17'h00005);
      host.send(CMD_WRITE, 2'h0, 2'h0, 17'h00000);
      rdc(4'h4, 32'h3);
      rdc(4'h8, pat);
      host.send(CMD_MODE_SET, 2'h0, 2'h3, 17'h00004);
      burst(2'h2, 1'b0, 1);
      host.send(CMD_MODE_SET, 2'h0, 2'h0, 17'h00002);
      burst(2'h1, 1'b1, 1);
      // On-the-fly burst field with address 12 high must give a full burst.
      host.send(CMD_MODE_SET, 2'h0, 2'h0, 17'h00001);
      // No write follows the two-clock write preamble, so no latency change is owed.
      host.send(CMD_MODE_SET, 2'h1, 2'h0, 17'h01800);
      rdc(4'h4, 32'h59);
      burst(2'h3, 1'b0, 2);
      host.send(CMD_MODE_SET, 2'h0, 2'h0, 17'h00000);
      host.send(CMD_MODE_SET, 2'h1, 2'h0, 17'h00400);
      repeat (3) @(negedge clock);
      chk(pins, {8'hff, 4'b1011});
      rdc(4'h4, 32'h21);
      host.send(CMD_MODE_SET, 2'h0, 2'h3, 17'h00000);
      rdc(4'h4, 32'h0);
      host.send(CMD_MODE_SET, 2'h1, 2'h0, 17'h00400);
      rdc(4'h4, 32'h0);
      host.send(CMD_READ, 2'h0, 2'h0, 17'h01000);
      repeat (14) begin
         @(negedge clock);
         chk({pins.strobe_oe, pins.dq_oe}, 2'b00);
      end
      host.send(CMD_ACTIVATE, 2'h1, 2'h2, 17'h05a5a);
      rdc(4'hc, 32'h40);
      host.send(CMD_ACTIVATE, 2'h1, 2'h2, 17'h00001);
      rdc(4'h4, 32'h100);
      wb(1'b1, 4'h4, 32'h100);
      rdc(4'h4, 32'h0);
      host.send(CMD_PRECHARGE, 2'h1, 2'h2, 17'h00000);
      rdc(4'hc, 32'h0);
      print_verdict();
   end
endmodule

`default_nettype wire
